// ===== sfc_pkg.sv
// Constants, register map and types for the shutter field counter block.
// Assumes a single 100 MHz clock and a simple strobe register port.
package sfc_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // Register word offsets
  localparam logic [4:0] OFS_MAIN_ACTION   = 5'h00;
  localparam logic [4:0] OFS_AUX_ACTION    = 5'h01;
  localparam logic [4:0] OFS_MAIN_LIMIT    = 5'h02;
  localparam logic [4:0] OFS_AUX_LIMIT     = 5'h03;
  localparam logic [4:0] OFS_MAIN_DELAY    = 5'h04;
  localparam logic [4:0] OFS_AUX_DELAY     = 5'h05;
  localparam logic [4:0] OFS_SYNC_MASK     = 5'h06;
  localparam logic [4:0] OFS_EXPOSURE_CNT  = 5'h07;
  localparam logic [4:0] OFS_SUBMASK_CNT   = 5'h08;
  localparam logic [4:0] OFS_START_DELAY   = 5'h09;
  localparam logic [4:0] OFS_PULSES        = 5'h0A;
  localparam logic [4:0] OFS_TOG_FIRST     = 5'h0B;
  localparam logic [4:0] OFS_TOG_SECOND    = 5'h0C;
  localparam logic [4:0] OFS_FINE_FIRST    = 5'h0D;
  localparam logic [4:0] OFS_FINE_SECOND   = 5'h0E;
  localparam logic [4:0] OFS_MISC          = 5'h0F;
  localparam logic [4:0] OFS_STATUS        = 5'h10;
  localparam logic [4:0] OFS_MAIN_COUNT    = 5'h11;
  localparam logic [4:0] OFS_AUX_COUNT     = 5'h12;

  // Field positions in the misc, delay and sync mask registers
  localparam int unsigned MISC_POL_BIT     = 0;
  localparam int unsigned MISC_INHIBIT_BIT = 1;
  localparam int unsigned MISC_SKIP1_BIT   = 2;
  localparam int unsigned MISC_FINE_VD_BIT = 3;
  localparam int unsigned DELAY_FIRST_BIT  = 13;
  localparam int unsigned SYNC_MASK_FIELD  = 0;
  localparam int unsigned SYNC_MASK_LINE   = 1;
  localparam int unsigned SYNC_MASK_AUX    = 2;

  // Action codes
  localparam logic [2:0] ACT_IDLE       = 3'h0;
  localparam logic [2:0] ACT_SINGLE     = 3'h1;
  localparam logic [2:0] ACT_REPEAT     = 3'h2;
  localparam logic [2:0] ACT_DELAYED    = 3'h3;
  localparam logic [2:0] ACT_DLY_REPEAT = 3'h4;
  localparam logic [2:0] ACT_EXPOSE     = 3'h5;
  localparam logic [2:0] ACT_READOUT    = 3'h6;
  localparam logic [2:0] ACT_FORCE_IDLE = 3'h7;

  // Reset values and special positions
  localparam logic [13:0] TOG_DISABLED  = 14'h3FFF;
  localparam logic [12:0] CNT_ZERO      = 13'h0000;
  localparam logic [12:0] CNT_ONE       = 13'h0001;
  localparam logic [13:0] PIX_ZERO      = 14'h0000;

  typedef enum logic [2:0] {
    cs_idle  = 3'b000,
    cs_wait  = 3'b001,
    cs_count = 3'b010,
    cs_hold  = 3'b011,
    cs_read  = 3'b100
  } sfc_cnt_st_t;

  typedef struct packed {
    sfc_cnt_st_t st;
    logic [2:0]  mode;
    logic [12:0] cnt;
    logic [12:0] dly;
  } sfc_ctr_t;

endpackage

// ===== sfc_shutter.sv
// Shutter timing: substrate-clear pulse string, exposure/readout masking,
// primary and secondary field counters, and a strobe register port.
// Assumes field_sync and line_sync are one-cycle pulses synchronous to clk_sys.
//
// The address-and-strobe port and the address map were chosen for this implementation.
module sfc_shutter (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        field_sync,
  input  wire logic        line_sync,
  input  wire logic        primary_gate_active_line,
  input  wire logic        sense_gate_in,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             substrate_clear_pulse,
  output logic             sense_gate_pulse,
  output logic             field_sync_out,
  output logic             line_sync_out
);

  typedef struct packed {
    logic [2:0]  main_action;
    logic [2:0]  aux_action;
    logic [12:0] main_limit;
    logic [11:0] aux_limit;
    logic [13:0] main_delay;
    logic [13:0] aux_delay;
    logic [2:0]  sync_mask;
    logic [12:0] exposure_cnt;
    logic [12:0] submask_cnt;
    logic [12:0] start_delay;
    logic [12:0] pulses;
    logic [13:0] tog_first;
    logic [13:0] tog_second;
    logic [13:0] fine_first;
    logic [13:0] fine_second;
    logic [3:0]  misc;
    sfc_pkg::sfc_ctr_t main_ctr;
    sfc_pkg::sfc_ctr_t aux_ctr;
    logic        mask_run;
    logic [13:0] mask_idx;
    logic [13:0] px;
    logic [12:0] sub_wait;
    logic [12:0] sub_left;
    logic        line_on;
    logic        line_last;
    logic        sh_pol;
    logic [13:0] sh_tog1;
    logic [13:0] sh_tog2;
    logic [13:0] sh_fine1;
    logic [13:0] sh_fine2;
    logic [15:0] rdata;
    logic        sub_out;
    logic        sg_out;
    logic        fs_out;
    logic        ls_out;
  } sfc_state_t;

  sfc_state_t st_q;
  sfc_state_t st_d;

  // Applies a written action code to a counter
  function automatic sfc_pkg::sfc_ctr_t ctr_action(input sfc_pkg::sfc_ctr_t c,
                                                   input logic [2:0] code,
                                                   input logic is_main);
    sfc_pkg::sfc_ctr_t r;
    r = c;
    case (code)
      sfc_pkg::ACT_SINGLE, sfc_pkg::ACT_REPEAT,
      sfc_pkg::ACT_DELAYED, sfc_pkg::ACT_DLY_REPEAT: begin
        r.st   = sfc_pkg::cs_wait;
        r.mode = code;
        r.cnt  = sfc_pkg::CNT_ZERO;
        r.dly  = sfc_pkg::CNT_ZERO;
      end
      sfc_pkg::ACT_EXPOSE: begin
        if (is_main) begin
          r.st   = sfc_pkg::cs_hold;
          r.mode = code;
        end
      end
      sfc_pkg::ACT_READOUT: begin
        if (is_main) begin
          r.st   = sfc_pkg::cs_read;
          r.mode = code;
        end
      end
      default: begin
        r.st   = sfc_pkg::cs_idle;
        r.mode = code;
        r.cnt  = sfc_pkg::CNT_ZERO;
        r.dly  = sfc_pkg::CNT_ZERO;
      end
    endcase
    return r;
  endfunction

  // Advances a counter at a field sync; start flags a new count cycle
  function automatic sfc_pkg::sfc_ctr_t ctr_field(input sfc_pkg::sfc_ctr_t c,
                                                  input logic [12:0] lim,
                                                  input logic [13:0] dly_cfg,
                                                  output logic start);
    sfc_pkg::sfc_ctr_t r;
    logic [12:0]       tgt;
    logic              delayed;
    r       = c;
    start   = 1'b0;
    delayed = (c.mode == sfc_pkg::ACT_DELAYED) || (c.mode == sfc_pkg::ACT_DLY_REPEAT);
    tgt     = delayed ? dly_cfg[12:0] : sfc_pkg::CNT_ZERO;
    case (c.st)
      sfc_pkg::cs_wait: begin
        if (c.dly >= tgt) begin
          r.st  = sfc_pkg::cs_count;
          r.cnt = sfc_pkg::CNT_ONE;
          start = 1'b1;
        end else begin
          r.dly = c.dly + sfc_pkg::CNT_ONE;
        end
      end
      sfc_pkg::cs_count: begin
        if (c.cnt >= lim) begin
          if (c.mode == sfc_pkg::ACT_REPEAT ||
              (c.mode == sfc_pkg::ACT_DLY_REPEAT && dly_cfg[sfc_pkg::DELAY_FIRST_BIT])) begin
            r.cnt = sfc_pkg::CNT_ONE;
            start = 1'b1;
          end else if (c.mode == sfc_pkg::ACT_DLY_REPEAT) begin
            r.st  = sfc_pkg::cs_wait;
            r.dly = CNT_ONE_IF_ZERO(dly_cfg);
            r.cnt = sfc_pkg::CNT_ZERO;
          end else begin
            r.st  = sfc_pkg::cs_idle;
            r.cnt = sfc_pkg::CNT_ZERO;
          end
        end else begin
          r.cnt = c.cnt + sfc_pkg::CNT_ONE;
        end
      end
      default: begin
        r = c;
      end
    endcase
    return r;
  endfunction

  // The field that ends a cycle already counts toward the following delay
  function automatic logic [12:0] CNT_ONE_IF_ZERO(input logic [13:0] d);
    return (d[12:0] == sfc_pkg::CNT_ZERO) ? sfc_pkg::CNT_ZERO : sfc_pkg::CNT_ONE;
  endfunction

  logic        main_start;
  logic        aux_start;
  logic [13:0] win_lo;
  logic [13:0] sg_hi;
  logic [13:0] sub_hi;
  logic        sg_mask;
  logic        sub_mask;
  logic        main_busy;
  logic        aux_busy;
  logic        in_pulse;
  logic        in_fine;
  logic        main_wr;

  always_comb begin
    st_d       = st_q;
    main_start = 1'b0;
    aux_start  = 1'b0;
    main_wr    = reg_wr && (reg_addr == sfc_pkg::OFS_MAIN_ACTION);

    // skip-first shifts the mask window by one field
    win_lo = {13'h0000, st_q.misc[sfc_pkg::MISC_SKIP1_BIT]};
    sg_hi  = win_lo + {1'b0, st_q.exposure_cnt};
    sub_hi = win_lo + {1'b0, st_q.submask_cnt};

    // masks come from the primary counter only
    sg_mask  = (st_q.main_ctr.st == sfc_pkg::cs_hold) ||
               (st_q.mask_run && st_q.mask_idx >= win_lo && st_q.mask_idx < sg_hi);
    sub_mask = (st_q.main_ctr.st == sfc_pkg::cs_hold) ||
               (st_q.main_ctr.st == sfc_pkg::cs_read && st_q.mask_idx < sub_hi) ||
               (st_q.mask_run && st_q.mask_idx >= win_lo && st_q.mask_idx < sub_hi);

    main_busy = st_q.main_ctr.st != sfc_pkg::cs_idle;
    aux_busy  = st_q.aux_ctr.st != sfc_pkg::cs_idle;

    // Field counters
    if (field_sync) begin
      st_d.main_ctr = ctr_field(st_q.main_ctr, st_q.main_limit, st_q.main_delay, main_start);
      st_d.aux_ctr  = ctr_field(st_q.aux_ctr, {1'b0, st_q.aux_limit}, st_q.aux_delay,
                                aux_start);
      if (st_q.mask_run || st_q.main_ctr.st == sfc_pkg::cs_read) begin
        if (st_q.mask_idx != sfc_pkg::TOG_DISABLED) begin
          st_d.mask_idx = st_q.mask_idx + 14'h0001;
        end
      end
      if (st_q.main_ctr.st == sfc_pkg::cs_read && st_q.mask_idx + 14'h0001 >= sub_hi) begin
        st_d.main_ctr.st = sfc_pkg::cs_idle;
      end
      // each new cycle restarts the mask window here
      if (main_start) begin
        st_d.mask_run = 1'b1;
        st_d.mask_idx = sfc_pkg::PIX_ZERO;
      end
    end

    // written actions take effect at once
    if (main_wr) begin
      st_d.main_ctr = ctr_action(st_q.main_ctr, reg_wdata[2:0], 1'b1);
      if (reg_wdata[2:0] == sfc_pkg::ACT_READOUT) begin
        st_d.mask_run = 1'b0;
        st_d.mask_idx = win_lo + {1'b0, st_q.exposure_cnt};
      end else if (reg_wdata[2:0] == sfc_pkg::ACT_IDLE ||
                   reg_wdata[2:0] == sfc_pkg::ACT_FORCE_IDLE) begin
        st_d.mask_run = 1'b0;
      end
    end
    if (reg_wr && reg_addr == sfc_pkg::OFS_AUX_ACTION) begin
      st_d.aux_ctr = ctr_action(st_q.aux_ctr, reg_wdata[2:0], 1'b0);
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        sfc_pkg::OFS_MAIN_ACTION:  st_d.main_action  = reg_wdata[2:0];
        sfc_pkg::OFS_AUX_ACTION:   st_d.aux_action   = reg_wdata[2:0];
        sfc_pkg::OFS_MAIN_LIMIT:   st_d.main_limit   = reg_wdata[12:0];
        sfc_pkg::OFS_AUX_LIMIT:    st_d.aux_limit    = reg_wdata[11:0];
        sfc_pkg::OFS_MAIN_DELAY:   st_d.main_delay   = reg_wdata[13:0];
        sfc_pkg::OFS_AUX_DELAY:    st_d.aux_delay    = reg_wdata[13:0];
        sfc_pkg::OFS_SYNC_MASK:    st_d.sync_mask    = reg_wdata[2:0];
        sfc_pkg::OFS_EXPOSURE_CNT: st_d.exposure_cnt = reg_wdata[12:0];
        sfc_pkg::OFS_SUBMASK_CNT:  st_d.submask_cnt  = reg_wdata[12:0];
        sfc_pkg::OFS_START_DELAY:  st_d.start_delay  = reg_wdata[12:0];
        sfc_pkg::OFS_PULSES:       st_d.pulses       = reg_wdata[12:0];
        sfc_pkg::OFS_TOG_FIRST:    st_d.tog_first    = reg_wdata[13:0];
        sfc_pkg::OFS_TOG_SECOND:   st_d.tog_second   = reg_wdata[13:0];
        sfc_pkg::OFS_FINE_FIRST:   st_d.fine_first   = reg_wdata[13:0];
        sfc_pkg::OFS_FINE_SECOND:  st_d.fine_second  = reg_wdata[13:0];
        sfc_pkg::OFS_MISC:         st_d.misc         = reg_wdata[3:0];
        default:                   st_d.misc         = st_q.misc;
      endcase
    end

    // Read data stand for exactly one cycle
    st_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        sfc_pkg::OFS_MAIN_ACTION:  st_d.rdata = {13'h0000, st_q.main_action};
        sfc_pkg::OFS_AUX_ACTION:   st_d.rdata = {13'h0000, st_q.aux_action};
        sfc_pkg::OFS_MAIN_LIMIT:   st_d.rdata = {3'h0, st_q.main_limit};
        sfc_pkg::OFS_AUX_LIMIT:    st_d.rdata = {4'h0, st_q.aux_limit};
        sfc_pkg::OFS_MAIN_DELAY:   st_d.rdata = {2'h0, st_q.main_delay};
        sfc_pkg::OFS_AUX_DELAY:    st_d.rdata = {2'h0, st_q.aux_delay};
        sfc_pkg::OFS_SYNC_MASK:    st_d.rdata = {13'h0000, st_q.sync_mask};
        sfc_pkg::OFS_EXPOSURE_CNT: st_d.rdata = {3'h0, st_q.exposure_cnt};
        sfc_pkg::OFS_SUBMASK_CNT:  st_d.rdata = {3'h0, st_q.submask_cnt};
        sfc_pkg::OFS_START_DELAY:  st_d.rdata = {3'h0, st_q.start_delay};
        sfc_pkg::OFS_PULSES:       st_d.rdata = {3'h0, st_q.pulses};
        sfc_pkg::OFS_TOG_FIRST:    st_d.rdata = {2'h0, st_q.tog_first};
        sfc_pkg::OFS_TOG_SECOND:   st_d.rdata = {2'h0, st_q.tog_second};
        sfc_pkg::OFS_FINE_FIRST:   st_d.rdata = {2'h0, st_q.fine_first};
        sfc_pkg::OFS_FINE_SECOND:  st_d.rdata = {2'h0, st_q.fine_second};
        sfc_pkg::OFS_MISC:         st_d.rdata = {12'h000, st_q.misc};
        sfc_pkg::OFS_STATUS:       st_d.rdata = {8'h00, sg_mask, sub_mask, st_q.aux_ctr.st,
                                                 st_q.main_ctr.st};
        sfc_pkg::OFS_MAIN_COUNT:   st_d.rdata = {3'h0, st_q.main_ctr.cnt};
        sfc_pkg::OFS_AUX_COUNT:    st_d.rdata = {3'h0, st_q.aux_ctr.cnt};
        default:                   st_d.rdata = 16'h0000;
      endcase
    end

    // Pixel position within the line
    if (line_sync) begin
      st_d.px = sfc_pkg::PIX_ZERO;
    end else if (st_q.px != sfc_pkg::TOG_DISABLED) begin
      st_d.px = st_q.px + 14'h0001;
    end

    // fine toggles may follow field sync instead of the gate line
    if (field_sync && st_q.misc[sfc_pkg::MISC_FINE_VD_BIT]) begin
      st_d.sh_fine1 = st_q.fine_first;
      st_d.sh_fine2 = st_q.fine_second;
    end

    // Line engine: one pulse line per line sync at most
    if (line_sync) begin
      if (primary_gate_active_line) begin
        // load the pulse string at the gate line
        st_d.sub_wait  = st_q.start_delay;
        st_d.sub_left  = st_q.pulses;
        st_d.line_on   = 1'b0;
        st_d.line_last = 1'b0;
        st_d.sh_pol    = st_q.misc[sfc_pkg::MISC_POL_BIT];
        st_d.sh_tog1   = st_q.tog_first;
        st_d.sh_tog2   = st_q.tog_second;
        if (!st_q.misc[sfc_pkg::MISC_FINE_VD_BIT]) begin
          st_d.sh_fine1 = st_q.fine_first;
          st_d.sh_fine2 = st_q.fine_second;
        end
      end else if (st_q.sub_wait != sfc_pkg::CNT_ZERO) begin
        st_d.sub_wait = st_q.sub_wait - sfc_pkg::CNT_ONE;
        st_d.line_on  = 1'b0;
      end else if (st_q.sub_left != sfc_pkg::CNT_ZERO) begin
        st_d.line_on   = 1'b1;
        st_d.line_last = st_q.sub_left == sfc_pkg::CNT_ONE;
        st_d.sub_left  = st_q.sub_left - sfc_pkg::CNT_ONE;
      end else begin
        st_d.line_on   = 1'b0;
        st_d.line_last = 1'b0;
      end
    end

    in_pulse = st_q.line_on && st_q.px >= st_q.sh_tog1 && st_q.px < st_q.sh_tog2;
    in_fine  = st_q.line_on && st_q.line_last && st_q.sh_fine1 != sfc_pkg::TOG_DISABLED &&
               st_q.px >= st_q.sh_fine1 && st_q.px < st_q.sh_fine2;
    // substrate masked to its idle level
    st_d.sub_out = sub_mask ? st_q.sh_pol : (st_q.sh_pol ^ (in_pulse || in_fine));
    st_d.sg_out  = sense_gate_in && !sg_mask && !st_q.misc[sfc_pkg::MISC_INHIBIT_BIT];

    st_d.fs_out = field_sync && !(st_q.sync_mask[sfc_pkg::SYNC_MASK_FIELD] &&
                  (main_busy || (st_q.sync_mask[sfc_pkg::SYNC_MASK_AUX] && aux_busy)));
    st_d.ls_out = line_sync && !(st_q.sync_mask[sfc_pkg::SYNC_MASK_LINE] &&
                  (main_busy || (st_q.sync_mask[sfc_pkg::SYNC_MASK_AUX] && aux_busy)));
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q             <= '0;
      st_q.fine_first  <= sfc_pkg::TOG_DISABLED;
      st_q.fine_second <= sfc_pkg::TOG_DISABLED;
      st_q.sh_fine1    <= sfc_pkg::TOG_DISABLED;
      st_q.sh_fine2    <= sfc_pkg::TOG_DISABLED;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata             = st_q.rdata;
  assign substrate_clear_pulse = st_q.sub_out;
  assign sense_gate_pulse      = st_q.sg_out;
  assign field_sync_out        = st_q.fs_out;
  assign line_sync_out         = st_q.ls_out;

  a_hold_sg_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_q.main_ctr.st == sfc_pkg::cs_hold |=> !sense_gate_pulse)
    else $error("sense gate seen during manual exposure");

  a_inhibit_sg: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_q.misc[sfc_pkg::MISC_INHIBIT_BIT] |=> !sense_gate_pulse)
    else $error("sense gate passed while inhibited");

  a_sub_masked: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sub_mask |=> substrate_clear_pulse == $past(st_q.sh_pol))
    else $error("substrate pulse during mask");

  a_force_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    main_wr && reg_wdata[2:0] == sfc_pkg::ACT_FORCE_IDLE
    |=> st_q.main_ctr.st == sfc_pkg::cs_idle && !st_q.mask_run)
    else $error("force idle not taken");

  a_single_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    field_sync && !main_wr && st_q.main_ctr.st == sfc_pkg::cs_count &&
    st_q.main_ctr.mode == sfc_pkg::ACT_SINGLE && st_q.main_ctr.cnt >= st_q.main_limit
    |=> st_q.main_ctr.st == sfc_pkg::cs_idle)
    else $error("single count did not return to idle");

  a_repeat_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    field_sync && !main_wr && st_q.main_ctr.st == sfc_pkg::cs_count &&
    st_q.main_ctr.mode == sfc_pkg::ACT_REPEAT && st_q.main_ctr.cnt >= st_q.main_limit
    |=> st_q.main_ctr.cnt == sfc_pkg::CNT_ONE && st_q.mask_idx == sfc_pkg::PIX_ZERO)
    else $error("repeating count did not wrap");

  a_count_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
    field_sync && !main_wr && st_q.main_ctr.st == sfc_pkg::cs_count &&
    st_q.main_ctr.cnt < st_q.main_limit
    |=> st_q.main_ctr.cnt == $past(st_q.main_ctr.cnt) + sfc_pkg::CNT_ONE)
    else $error("field count step wrong");

  a_readout_entry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    main_wr && reg_wdata[2:0] == sfc_pkg::ACT_READOUT
    |=> st_q.main_ctr.st == sfc_pkg::cs_read && !sg_mask)
    else $error("readout did not release sense gate");

  // string changes only at line sync
  a_one_per_line: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !line_sync |=> $stable(st_q.sub_left) && $stable(st_q.line_on))
    else $error("pulse string advanced off a line sync");

  a_delay_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
    field_sync && !main_wr && st_q.main_ctr.st == sfc_pkg::cs_wait &&
    st_q.main_ctr.mode == sfc_pkg::ACT_DELAYED && st_q.main_ctr.dly < st_q.main_delay[12:0]
    |=> st_q.main_ctr.st == sfc_pkg::cs_wait &&
        st_q.main_ctr.dly == $past(st_q.main_ctr.dly) + sfc_pkg::CNT_ONE)
    else $error("delay did not advance");

endmodule

// ===== sfc_ccd_model.sv
// Sensor-side model: counts substrate and sense-gate rising edges per field.
// Assumes inputs synchronous to clk_sys; counts clear at each field_sync.
module sfc_ccd_model (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       field_sync,
  input  wire logic       substrate_clear_pulse,
  input  wire logic       sense_gate_pulse,
  output logic      [7:0] sub_n,
  output logic      [7:0] sg_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sub_q;
  logic sg_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sub_q <= 1'b0;
      sg_q  <= 1'b0;
      sub_n <= 8'h00;
      sg_n  <= 8'h00;
    end else begin
      sub_q <= substrate_clear_pulse;
      sg_q  <= sense_gate_pulse;
      sub_n <= field_sync ? 8'h00 : sub_n + 8'(substrate_clear_pulse & ~sub_q);
      sg_n  <= field_sync ? 8'h00 : sg_n + 8'(sense_gate_pulse & ~sg_q);
    end
  end
endmodule

// ===== sfc_shutter_bench.sv
// Self-checking bench for the shutter block: register tasks and field timing.
// Assumes six 20-cycle lines per field, line 0 being the sense-gate line.
module sfc_shutter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, arst_n = 1'b0, fs = 1'b0, ls = 1'b0, gate = 1'b0, sgi = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sub, sg;
  logic fso, lso;
  logic [7:0] sub_n, sg_n;
  int n_fail = 0, tests_run = 0;
  int n_fso = 0, n_lso = 0, fs_mark = 0, ls_mark = 0;
  always #5 clk_sys = ~clk_sys;
  // Counts forwarded sync pulses for the sync-mask checks
  always @(posedge clk_sys) begin
    if (fso === 1'b1)
      n_fso <= n_fso + 1;
    if (lso === 1'b1)
      n_lso <= n_lso + 1;
  end
  sfc_shutter i_sfc_shutter (.clk_sys(clk_sys), .arst_n(arst_n), .field_sync(fs),
    .line_sync(ls), .primary_gate_active_line(gate), .sense_gate_in(sgi),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .substrate_clear_pulse(sub), .sense_gate_pulse(sg),
    .field_sync_out(fso), .line_sync_out(lso));
  sfc_ccd_model i_sfc_ccd_model (.clk_sys(clk_sys), .arst_n(arst_n), .field_sync(fs),
    .substrate_clear_pulse(sub), .sense_gate_pulse(sg), .sub_n(sub_n), .sg_n(sg_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // One field, then compare pulse counts seen by the sensor
  task automatic fld(input logic [7:0] es, input logic [7:0] eg);
    @(posedge clk_sys) fs <= 1'b1;
    @(posedge clk_sys) fs <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      ls <= 1'b1;
      gate <= (i == 0);
      sgi <= (i == 0);
      @(posedge clk_sys);
      ls <= 1'b0;
      sgi <= 1'b0;
      repeat (18) @(posedge clk_sys);
    end
    chk({8'h00, sub_n}, {8'h00, es});
    chk({8'h00, sg_n}, {8'h00, eg});
  endtask
  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(5'h0F, 16'h0000);
    rd(5'h0D, 16'h3FFF);
    rd(5'h1F, 16'h0000);
    wr(5'h0A, 16'h0002);
    wr(5'h0B, 16'h0002);
    wr(5'h0C, 16'h0005);
    fld(8'h02, 8'h01);
    fld(8'h02, 8'h01);
    wr(5'h09, 16'h0004);
    fld(8'h01, 8'h01);
    wr(5'h09, 16'h0000);
    wr(5'h0D, 16'h000A);
    wr(5'h0E, 16'h000C);
    fld(8'h03, 8'h01);
    wr(5'h0D, 16'h3FFF);
    wr(5'h0F, 16'h0002);
    fld(8'h02, 8'h00);
    wr(5'h0F, 16'h0000);
    wr(5'h07, 16'h0001);
    wr(5'h08, 16'h0002);
    wr(5'h02, 16'h0003);
    wr(5'h00, 16'h0001);
    fld(8'h00, 8'h00);
    fld(8'h00, 8'h01);
    fld(8'h02, 8'h01);
    rd(5'h11, 16'h0003);
    fld(8'h02, 8'h01);
    rd(5'h10, 16'h0000);
    wr(5'h0F, 16'h0004);
    wr(5'h08, 16'h0001);
    wr(5'h00, 16'h0001);
    fld(8'h02, 8'h01);
    fld(8'h00, 8'h00);
    wr(5'h00, 16'h0007);
    rd(5'h10, 16'h0000);
    wr(5'h0F, 16'h0000);
    wr(5'h00, 16'h0005);
    fld(8'h00, 8'h00);
    // Read fields remain in the substrate mask window
    wr(5'h08, 16'h0003);
    wr(5'h00, 16'h0006);
    fld(8'h00, 8'h01);
    wr(5'h00, 16'h0007);
    wr(5'h03, 16'h0002);
    wr(5'h01, 16'h0001);
    fld(8'h02, 8'h01);
    rd(5'h12, 16'h0001);
    rd(5'h10, 16'h0010);
    wr(5'h07, 16'h0000);
    wr(5'h08, 16'h0000);
    wr(5'h02, 16'h0002);
    wr(5'h00, 16'h0002);
    fld(8'h02, 8'h01);
    fld(8'h02, 8'h01);
    fld(8'h02, 8'h01);
    rd(5'h11, 16'h0001);
    wr(5'h00, 16'h0007);
    wr(5'h04, 16'h0002);
    wr(5'h00, 16'h0003);
    fld(8'h02, 8'h01);
    rd(5'h10, 16'h0001);
    repeat (2) fld(8'h02, 8'h01);
    rd(5'h11, 16'h0001);
    // Delay only before the first cycle: wraps straight back to one
    wr(5'h00, 16'h0007);
    wr(5'h04, 16'h2002);
    wr(5'h00, 16'h0004);
    repeat (5) fld(8'h02, 8'h01);
    rd(5'h10, 16'h0002);
    // Delay between cycles: waits again after the limit
    wr(5'h00, 16'h0007);
    wr(5'h04, 16'h0002);
    wr(5'h00, 16'h0004);
    repeat (5) fld(8'h02, 8'h01);
    rd(5'h10, 16'h0001);
    repeat (2) fld(8'h02, 8'h01);
    rd(5'h10, 16'h0002);
    // Repeating masks, with both sync outputs masked while busy
    wr(5'h00, 16'h0007);
    wr(5'h07, 16'h0001);
    wr(5'h08, 16'h0001);
    wr(5'h06, 16'h0003);
    fs_mark = n_fso;
    ls_mark = n_lso;
    wr(5'h00, 16'h0002);
    fld(8'h00, 8'h00);
    fld(8'h02, 8'h01);
    fld(8'h00, 8'h00);
    chk(16'(n_fso - fs_mark), 16'h0000);
    chk(16'(n_lso - ls_mark), 16'h0000);
    wr(5'h00, 16'h0007);
    fld(8'h02, 8'h01);
    chk(16'(n_fso - fs_mark), 16'h0001);
    chk(16'(n_lso - ls_mark), 16'h0006);
    finish_test;
  end
endmodule
